// ---- hdl/ref_clock_output_select.sv ----
`timescale 1ns/10ps
module ref_clock_output_select #(
    parameter bit quad_variant = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [1:0]  clock_strap_code,
    input  wire logic        power_down_pin,
    input  wire logic        overrange_c,
    input  wire logic        overrange_d,
    output logic             spare_out_c,
    output logic             spare_out_c_oe,
    output logic             spare_out_d,
    output logic             spare_out_d_oe
);

    ref_clock_output_pkg::control_t      ctrl;
    ref_clock_output_pkg::pin_function_t out_c_ref_clock_function;
    ref_clock_output_pkg::pin_function_t out_d_ref_clock_function;
    ref_clock_output_pkg::pin_function_t active_c;
    ref_clock_output_pkg::pin_function_t active_d;
    ref_clock_output_pkg::pin_function_t requested [2];
    ref_clock_output_pkg::pin_function_t active    [2];
    ref_clock_output_pkg::pin_drive_t    drive     [2];
    logic                                overrange [2];
    logic [1:0]                          strap;
    logic                                power_down;
    logic [2:0]                          div_count;
    logic [1:0]                          sel_c;
    logic [1:0]                          sel_d;
    logic                                setup_phase;
    logic                                write_take;
    logic [31:0]                         read_word;
    logic                                mapped;

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign setup_phase = psel && !penable;
    assign write_take  = psel && penable && pready && pwrite;
    assign mapped      = (paddr == ref_clock_output_pkg::control_offset) ||
                         (paddr == ref_clock_output_pkg::status_offset);

    // status reports the functions on the pins, after any switch delay
    always_comb begin
        read_word = 32'h00000000;
        if (paddr == ref_clock_output_pkg::control_offset) begin
            read_word[ref_clock_output_pkg::ctrl_override_bit]  = ctrl.strap_override_enable;
            read_word[ref_clock_output_pkg::ctrl_overrange_bit] = ctrl.overrange_out_enable;
            read_word[ref_clock_output_pkg::ctrl_c_mode_lsb +: 2] = ctrl.out_c_clock_mode;
            read_word[ref_clock_output_pkg::ctrl_d_mode_lsb +: 2] = ctrl.out_d_clock_mode;
        end else if (paddr == ref_clock_output_pkg::status_offset) begin
            read_word[ref_clock_output_pkg::stat_strap_lsb +: 2] = strap;
            read_word[ref_clock_output_pkg::stat_power_bit]      = power_down;
            read_word[ref_clock_output_pkg::stat_c_func_lsb +: 3] = active_c;
            read_word[ref_clock_output_pkg::stat_d_func_lsb +: 3] = active_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            // zero wait states: every access cycle completes at once
            pready <= setup_phase;
            if (setup_phase) begin
                prdata  <= pwrite ? 32'h00000000 : read_word;
                pslverr <= !mapped;
            end
        end
    end

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // all four fields change together, on the accepted access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl.strap_override_enable <= ref_clock_output_pkg::bit_reset;
            ctrl.overrange_out_enable  <= ref_clock_output_pkg::bit_reset;
            ctrl.out_c_clock_mode      <= ref_clock_output_pkg::mode_reset;
            ctrl.out_d_clock_mode      <= ref_clock_output_pkg::mode_reset;
        end else if (write_take && paddr == ref_clock_output_pkg::control_offset) begin
            ctrl.strap_override_enable <= pwdata[ref_clock_output_pkg::ctrl_override_bit];
            ctrl.overrange_out_enable  <= pwdata[ref_clock_output_pkg::ctrl_overrange_bit];
            ctrl.out_c_clock_mode <= pwdata[ref_clock_output_pkg::ctrl_c_mode_lsb +: 2];
            ctrl.out_d_clock_mode <= pwdata[ref_clock_output_pkg::ctrl_d_mode_lsb +: 2];
        end
    end

    // ------------------------------------------------------------
    // strap and power-down capture
    // ------------------------------------------------------------
    // sampled every cycle, so straps act straight after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap      <= ref_clock_output_pkg::mode_reset;
            // pins stay off until the real pin level has been seen
            power_down <= ref_clock_output_pkg::power_down_reset;
        end else begin
            strap      <= clock_strap_code;
            power_down <= power_down_pin;
        end
    end

    // ------------------------------------------------------------
    // free-running divider
    // ------------------------------------------------------------
    // never cleared after reset, so switch points stay on a fixed grid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= ref_clock_output_pkg::div_reset;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // function selection
    // ------------------------------------------------------------
    // override swaps the whole source for both pins at once
    always_comb begin
        if (ctrl.strap_override_enable) begin
            sel_c = ctrl.out_c_clock_mode;
            sel_d = ctrl.out_d_clock_mode;
        end else begin
            sel_c = strap;
            sel_d = (strap != ref_clock_output_pkg::mode_none) ?
                    ref_clock_output_pkg::mode_ref1 : ref_clock_output_pkg::mode_none;
        end
    end

    function automatic ref_clock_output_pkg::pin_function_t pick(
        input logic [1:0] mode,
        input logic       clock_allowed,
        input logic       overrange_on
    );
        ref_clock_output_pkg::pin_function_t fn;
        fn = ref_clock_output_pkg::fn_off;
        if (mode != ref_clock_output_pkg::mode_none) begin
            if (clock_allowed) begin
                unique case (mode)
                    ref_clock_output_pkg::mode_ref1: fn = ref_clock_output_pkg::fn_ref1;
                    ref_clock_output_pkg::mode_ref2: fn = ref_clock_output_pkg::fn_ref2;
                    ref_clock_output_pkg::mode_ref4: fn = ref_clock_output_pkg::fn_ref4;
                    default:                         fn = ref_clock_output_pkg::fn_off;
                endcase
            end
        // over-range only reaches a pin with no clock mode on it
        end else if (overrange_on && quad_variant) begin
            fn = ref_clock_output_pkg::fn_overrange;
        end
        return fn;
    endfunction : pick

    // clock mode wins over over-range; power-down forces both off
    always_comb begin
        if (power_down) begin
            out_c_ref_clock_function = ref_clock_output_pkg::fn_off;
            out_d_ref_clock_function = ref_clock_output_pkg::fn_off;
        end else begin
            out_c_ref_clock_function = pick(sel_c, 1'b1, ctrl.overrange_out_enable);
            // d with a mode set but c idle stays off rather than over-range
            out_d_ref_clock_function = pick(sel_d, sel_c != ref_clock_output_pkg::mode_none,
                                            ctrl.overrange_out_enable);
        end
    end

    // ------------------------------------------------------------
    // pin drivers: index 0 is output c, index 1 output d
    // ------------------------------------------------------------
    // both pins share one divider, so c and d clocks stay phase aligned
    assign requested[0] = out_c_ref_clock_function;
    assign requested[1] = out_d_ref_clock_function;
    assign overrange[0] = overrange_c;
    assign overrange[1] = overrange_d;

    // an unused pin still has a driver; its enable keeps it quiet
    for (genvar ch = 0; ch < 2; ch++) begin : g_pin
        spare_pin_driver i_pin (
            .clk        (pclk),
            .rst_n      (presetn),
            .requested  (requested[ch]),
            .div_count  (div_count),
            .overrange  (overrange[ch]),
            .pin_level  (drive[ch].level),
            .pin_enable (drive[ch].enable),
            .active     (active[ch])
        );
    end

    assign active_c       = active[0];
    assign active_d       = active[1];
    assign spare_out_c    = drive[0].level;
    assign spare_out_c_oe = drive[0].enable;
    assign spare_out_d    = drive[1].level;
    assign spare_out_d_oe = drive[1].enable;

endmodule : ref_clock_output_select

// ---- hdl/ref_clock_output_pkg.sv ----
package ref_clock_output_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] control_offset = 12'h000;
    localparam logic [11:0] status_offset  = 12'h004;

    // control field positions
    localparam int ctrl_override_bit  = 0;
    localparam int ctrl_overrange_bit = 1;
    localparam int ctrl_c_mode_lsb    = 2;
    localparam int ctrl_d_mode_lsb    = 4;

    // status field positions
    localparam int stat_strap_lsb     = 0;
    localparam int stat_power_bit     = 2;
    localparam int stat_c_func_lsb    = 4;
    localparam int stat_d_func_lsb    = 8;

    // reset values
    localparam logic [1:0] mode_reset = 2'h0;
    localparam logic       bit_reset  = 1'b0;
    localparam logic       power_down_reset = 1'b1;
    localparam logic [2:0] div_reset        = 3'h0;

    // clock mode codes shared by strap and mode fields
    localparam logic [1:0] mode_none = 2'h0;
    localparam logic [1:0] mode_ref1 = 2'h1;
    localparam logic [1:0] mode_ref2 = 2'h2;
    localparam logic [1:0] mode_ref4 = 2'h3;

    // free-running divider: bit 0 toggles every cycle
    localparam int          div_width  = 3;
    localparam logic [2:0]  div_wrap   = 3'h7;

    typedef enum logic [2:0] {
        fn_off       = 3'h0,
        fn_overrange = 3'h1,
        fn_ref1      = 3'h2,
        fn_ref2      = 3'h3,
        fn_ref4      = 3'h4
    } pin_function_t;

    typedef struct packed {
        logic       strap_override_enable;
        logic       overrange_out_enable;
        logic [1:0] out_c_clock_mode;
        logic [1:0] out_d_clock_mode;
    } control_t;

    typedef struct packed {
        logic level;
        logic enable;
    } pin_drive_t;

endpackage : ref_clock_output_pkg

// ---- hdl/spare_pin_driver.sv ----
`timescale 1ns/10ps
module spare_pin_driver (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire ref_clock_output_pkg::pin_function_t requested,
    input  wire logic [2:0]                          div_count,
    input  wire logic                                overrange,
    output logic                                     pin_level,
    output logic                                     pin_enable,
    output ref_clock_output_pkg::pin_function_t      active
);

    // ------------------------------------------------------------
    // glitch-free switch point
    // ------------------------------------------------------------
    // the ref2 and ref4 taps fall low as the count wraps to zero, where ref1 starts a high phase,
    // so a change of source there cannot cut a high phase short; costs up to 8 cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= ref_clock_output_pkg::fn_off;
        end else if (requested == ref_clock_output_pkg::fn_off) begin
            active <= ref_clock_output_pkg::fn_off;
        end else if (div_count == ref_clock_output_pkg::div_wrap) begin
            active <= requested;
        end
    end

    // ------------------------------------------------------------
    // registered pin
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_level  <= 1'b0;
            pin_enable <= 1'b0;
        end else begin
            pin_enable <= (active != ref_clock_output_pkg::fn_off);
            unique case (active)
                ref_clock_output_pkg::fn_off:       pin_level <= 1'b0;
                ref_clock_output_pkg::fn_overrange: pin_level <= overrange;
                ref_clock_output_pkg::fn_ref1:      pin_level <= ~div_count[0];
                ref_clock_output_pkg::fn_ref2:      pin_level <= div_count[1];
                ref_clock_output_pkg::fn_ref4:      pin_level <= div_count[2];
                default:                            pin_level <= 1'b0;
            endcase
        end
    end

endmodule : spare_pin_driver

// ---- verif/ref_clock_output_checker_sva.sv ----
`timescale 1ns/10ps
module ref_clock_output_checker #(
    parameter bit quad_variant = 1'b1
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        power_down_pin,
    input wire logic        spare_out_c,
    input wire logic        spare_out_c_oe,
    input wire logic        spare_out_d,
    input wire logic        spare_out_d_oe
);
    // ------------------------------------------------------------
    // bus handshake and pin enables
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_ready_one_cycle: assert property (s_done |=> !pready)
        else $error("pready held too long");
    a_err_unmapped: assert property ((s_done and (paddr != 12'h000 && paddr != 12'h004))
                                     |-> pslverr)
        else $error("unmapped access not refused");
    a_err_data_zero: assert property ((s_done and (pslverr && !pwrite)) |-> prdata == 32'h0)
        else $error("refused read returned data");
    // pin must be off within three edges of the pin going high
    a_pd_off_c: assert property (power_down_pin [*4] |-> !spare_out_c_oe)
        else $error("output c driven in power-down");
    a_pd_off_d: assert property (power_down_pin [*4] |-> !spare_out_d_oe)
        else $error("output d driven in power-down");
    a_off_pin_low: assert property (!spare_out_c_oe |-> !spare_out_c)
        else $error("output c level while disabled");
    a_off_d_low: assert property (!spare_out_d_oe |-> !spare_out_d)
        else $error("output d level while disabled");
    a_d_needs_c: assert property (spare_out_d_oe |-> spare_out_c_oe)
        else $error("output d driven without output c");
endmodule : ref_clock_output_checker

bind ref_clock_output_select ref_clock_output_checker #(.quad_variant(quad_variant)) i_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .power_down_pin(power_down_pin), .spare_out_c(spare_out_c),
    .spare_out_c_oe(spare_out_c_oe), .spare_out_d(spare_out_d), .spare_out_d_oe(spare_out_d_oe));

// ---- verif/ref_clock_sink.sv ----
`timescale 1ns/10ps
module ref_clock_sink (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       pin,
    input  wire logic       pin_oe,
    output logic [7:0]      period
);
    // ------------------------------------------------------------
    // period meter of the receiving logic
    // ------------------------------------------------------------
    logic       last;
    logic [7:0] count;
    // an undriven pin reads as no clock, like a floating input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last   <= 1'b0;
            count  <= 8'h00;
            period <= 8'h00;
        end else begin
            last <= pin && pin_oe;
            if (pin && pin_oe && !last) begin
                period <= count;
                count  <= 8'h01;
            end else begin
                if (count != 8'hFF) count <= count + 8'h01;
                // a stalled clock must not leave a stale period behind
                if (count > 8'h10) period <= 8'h00;
            end
        end
    end
endmodule : ref_clock_sink

// ---- verif/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [1:0]  clock_strap_code;
    logic        power_down_pin, overrange_c, overrange_d;
    logic        spare_out_c, spare_out_c_oe, spare_out_d, spare_out_d_oe;
    logic [7:0]  per_c, per_d;
    int          fail_count, num_checks, cycles = 0;

    ref_clock_output_select #(.quad_variant(1'b1)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .clock_strap_code(clock_strap_code), .power_down_pin(power_down_pin),
        .overrange_c(overrange_c), .overrange_d(overrange_d), .spare_out_c(spare_out_c),
        .spare_out_c_oe(spare_out_c_oe), .spare_out_d(spare_out_d),
        .spare_out_d_oe(spare_out_d_oe));
    ref_clock_sink i_sink_c (.clk(pclk), .rst_n(presetn), .pin(spare_out_c),
        .pin_oe(spare_out_c_oe), .period(per_c));
    ref_clock_sink i_sink_d (.clk(pclk), .rst_n(presetn), .pin(spare_out_d),
        .pin_oe(spare_out_d_oe), .period(per_d));

    // ------------------------------------------------------------
    // bus and comparison tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] period_of(input logic [2:0] f);
        case (f)
            3'h2:    return 8'h02;
            3'h3:    return 8'h04;
            3'h4:    return 8'h08;
            default: return 8'h00;
        endcase
    endfunction : period_of

    // long wait: clock start waits for the divider wrap, stale periods clear
    task automatic expect_fn(input logic [2:0] fc, input logic [2:0] fd);
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h004, 32'h0);
        check("c function", {29'h0, fc}, {29'h0, q[6:4]});
        check("d function", {29'h0, fd}, {29'h0, q[10:8]});
        check("c period", {24'h0, period_of(fc)}, {24'h0, per_c});
        check("d period", {24'h0, period_of(fd)}, {24'h0, per_d});
    endtask : expect_fn

    task automatic run(input logic [1:0] s, input logic [31:0] c, input logic [2:0] fc, fd);
        clock_strap_code <= s;
        apb(1'b1, 12'h000, c);
        expect_fn(fc, fd);
    endtask : run

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            results();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, power_down_pin, overrange_c, overrange_d} = 7'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        clock_strap_code = 2'h1;
        fail_count = 0;
        num_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        expect_fn(3'h2, 3'h2);
        check("strap status", 32'h1, {30'h0, q[1:0]});
        apb(1'b0, 12'h000, 32'h0);
        check("control reset", 32'h0, q);
        for (int s = 1; s < 4; s++) run(2'(s), 32'h3C, 3'(s + 1), 3'h2);
        run(2'h0, 32'h00, 3'h0, 3'h0);
        run(2'h0, 32'h02, 3'h1, 3'h1);
        overrange_c <= 1'b1;
        overrange_d <= 1'b1;
        repeat (4) @(posedge pclk);
        check("c over-range level", 32'h1, {31'h0, spare_out_c});
        check("d over-range level", 32'h1, {31'h0, spare_out_d});
        overrange_c <= 1'b0;
        overrange_d <= 1'b0;
        for (int m = 0; m < 4; m++) begin
            run(2'h1, 32'h31 | (m << 2), m ? 3'(m + 1) : 3'h0, m ? 3'h4 : 3'h0);
        end
        run(2'h0, 32'h0B, 3'h3, 3'h1);
        run(2'h0, 32'h13, 3'h1, 3'h0);
        run(2'h1, 32'h15, 3'h2, 3'h2);
        power_down_pin <= 1'b1;
        expect_fn(3'h0, 3'h0);
        check("power-down status", 32'h1, {31'h0, q[2]});
        power_down_pin <= 1'b0;
        expect_fn(3'h2, 3'h2);
        apb(1'b1, 12'h008, 32'hFF);
        check("write refused", 32'h1, {31'h0, err});
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped read", 32'h0, q);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b0, 12'h000, 32'h0);
        check("control kept", 32'h15, q);
        results();
    end
endmodule : tb_top
